/* File: design/pwm_match_flags.sv */
module pwm_match_flags
   import pwm_sync_pkg::*;
(
   // Clock and reset.
   input  wire logic       clock_in,
   input  wire logic       rst_b_in,
   // Events and control.
   input  wire logic       enable_in,
   input  wire logic [3:0] match_in,
   input  wire logic [3:0] flag_clear_in,
   input  wire logic [3:0] irq_enable_in,
   // Status.
   output logic [3:0]      flag_out,
   output logic [3:0]      irq_out
);
   // ----------------------------------------------------------------
   // Flags
   // ----------------------------------------------------------------
   logic [3:0] match_d;
   logic [3:0] next_flag;
   logic [3:0] next_irq;

   always_comb begin
      next_flag = (flag_out & ~flag_clear_in) |
                  (match_in & ~match_d);
      if (!enable_in) begin
         next_flag = 4'h0;
      end
      next_irq = next_flag & irq_enable_in;
   end

   always_ff @(posedge clock_in) begin
      if (!rst_b_in) begin
         match_d  <= 4'h0;
         flag_out <= 4'h0;
         irq_out  <= 4'h0;
      end else begin
         match_d  <= match_in;
         flag_out <= next_flag;
         irq_out  <= next_irq;
      end
   end

   property p_flag_off;
      @(posedge clock_in) disable iff (!rst_b_in)
      !$past(enable_in) |-> flag_out == 4'h0;
   endproperty
   a_flag_off: assert property (p_flag_off)
      else $error("flag set while disabled");
   property p_irq_gated;
      @(posedge clock_in) disable iff (!rst_b_in)
      irq_out == (flag_out & $past(irq_enable_in));
   endproperty
   a_irq_gated: assert property (p_irq_gated)
      else $error("irq not gated by enable");
endmodule

/* File: design/pwm_offset_sync_reload.sv */
module pwm_offset_sync_reload
   import pwm_sync_pkg::*;
#(
   parameter int WIDTH = COUNT_W,
   parameter int PEERS = PEER_N
) (
   // Clock and reset.
   input  wire logic             clock_in,
   input  wire logic             rst_b_in,
   // Module control.
   input  wire logic             enable_in,
   input  wire logic [1:0]       wave_mode_in,
   input  wire logic             sleep_in,
   input  wire logic [1:0]       clock_source_in,
   // Offset control.
   input  wire logic [1:0]       offset_mode_select_in,
   input  wire logic [1:0]       offset_source_select_in,
   input  wire logic [PEERS-1:0] peer_offset_match_in,
   // Buffered counts.
   input  wire logic [WIDTH-1:0] phase_count_in,
   input  wire logic [WIDTH-1:0] duty_count_in,
   input  wire logic [WIDTH-1:0] period_count_in,
   input  wire logic [WIDTH-1:0] offset_count_in,
   input  wire logic             offset_direction_shadow_in,
   // Reload control.
   input  wire logic             load_arm_set_in,
   input  wire logic             load_arm_clear_in,
   input  wire logic             load_on_trigger_in,
   input  wire logic [1:0]       load_trigger_select_in,
   input  wire logic [PEERS-1:0] peer_load_in,
   // Interrupt control.
   input  wire logic [3:0]       irq_enable_in,
   input  wire logic [3:0]       flag_clear_in,
   // Timer and events.
   output logic [WIDTH-1:0]      modulator_timer_out,
   output logic                  counting_down_out,
   output logic                  offset_match_event_out,
   output logic                  period_event_out,
   output logic                  load_event_out,
   output logic                  load_arm_out,
   // Active counts.
   output logic [WIDTH-1:0]      phase_active_out,
   output logic [WIDTH-1:0]      duty_active_out,
   output logic [WIDTH-1:0]      period_active_out,
   output logic [WIDTH-1:0]      offset_active_out,
   output logic                  offset_match_direction_out,
   // Interrupt flags.
   output logic [3:0]            irq_flag_out,
   output logic [3:0]            irq_out
);
   // ----------------------------------------------------------------
   // Clock gating in sleep, center-mode decode and master match select
   // ----------------------------------------------------------------
   logic run_ok;
   logic center;
   logic master_hit;

   always_comb begin
      run_ok = enable_in && (!sleep_in ||
               clock_source_in == CLK_SRC_FAST_OSC ||
               clock_source_in == CLK_SRC_SLOW_OSC);
      center = (wave_mode_in == WAVE_CENTER);
      master_hit = 1'b0;
      if (offset_source_select_in < PEERS[1:0]) begin
         master_hit = peer_offset_match_in[offset_source_select_in];
      end
   end

   // ----------------------------------------------------------------
   // Timer
   // ----------------------------------------------------------------
   run_state_t       state;
   run_state_t       next_state;
   logic [WIDTH-1:0] next_timer;
   logic             next_down;
   logic             next_period_ev;
   logic             next_offset_ev;
   logic             at_period;
   logic             load_now;
   logic             seen_master;
   logic             next_seen_master;

   function automatic logic [WIDTH-1:0] step(input logic [WIDTH-1:0] t,
                                            input logic down);
      step = down ? t - 1'b1 : t + 1'b1;
   endfunction

   always_comb begin
      next_state       = state;
      next_timer       = modulator_timer_out;
      next_down        = counting_down_out;
      next_seen_master = seen_master;
      at_period = (modulator_timer_out == period_active_out);
      next_period_ev = 1'b0;
      next_offset_ev = 1'b0;
      if (!enable_in) begin
         next_state       = RUN_IDLE;
         next_timer       = TIMER_ZERO;
         next_down        = 1'b0;
         next_seen_master = 1'b0;
      end else if (run_ok) begin
         case (state)
            RUN_IDLE: begin
               if (offset_mode_select_in == OFFSET_INDEPENDENT) begin
                  next_state = RUN_COUNT;
               end else begin
                  next_state = RUN_WAIT;
               end
            end
            RUN_WAIT, RUN_STOPPED: begin
               if (offset_mode_select_in == OFFSET_INDEPENDENT) begin
                  next_state = RUN_COUNT;
               end else if (master_hit) begin
                  next_state       = RUN_COUNT;
                  next_seen_master = 1'b1;
               end
            end
            RUN_COUNT: begin
               if (offset_mode_select_in == OFFSET_CONTINUOUS &&
                   master_hit && seen_master) begin
                  next_timer = TIMER_RESTART;
                  next_down  = 1'b0;
               end else if (center) begin
                  if (!counting_down_out && at_period) begin
                     next_down  = 1'b1;
                     next_timer = step(modulator_timer_out, 1'b1);
                  end else if (counting_down_out &&
                               modulator_timer_out == TIMER_ZERO) begin
                     next_period_ev = 1'b1;
                     next_down      = 1'b0;
                     next_timer     = TIMER_ZERO;
                  end else begin
                     next_timer = step(modulator_timer_out,
                                       counting_down_out);
                  end
               end else if (at_period) begin
                  next_period_ev = 1'b1;
                  next_timer     = TIMER_ZERO;
                  if (offset_mode_select_in == OFFSET_ONE_SHOT) begin
                     next_state = RUN_STOPPED;
                  end
               end else begin
                  next_timer = step(modulator_timer_out, 1'b0);
               end
               if (modulator_timer_out == offset_active_out &&
                   (!center ||
                    counting_down_out == offset_match_direction_out)) begin
                  next_offset_ev = 1'b1;
               end
               if (offset_mode_select_in == OFFSET_CONTINUOUS &&
                   master_hit) begin
                  next_seen_master = 1'b1;
               end
            end
            default: begin
               next_state = RUN_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge clock_in) begin
      if (!rst_b_in) begin
         state                  <= RUN_IDLE;
         modulator_timer_out    <= TIMER_ZERO;
         counting_down_out      <= 1'b0;
         period_event_out       <= 1'b0;
         offset_match_event_out <= 1'b0;
         seen_master            <= 1'b0;
      end else begin
         state                  <= next_state;
         modulator_timer_out    <= next_timer;
         counting_down_out      <= next_down;
         period_event_out       <= next_period_ev;
         offset_match_event_out <= next_offset_ev;
         seen_master            <= next_seen_master;
      end
   end

   // ----------------------------------------------------------------
   // Reload and active counts
   // ----------------------------------------------------------------
   logic             reload_pulse;
   logic [WIDTH-1:0] next_phase;
   logic [WIDTH-1:0] next_duty;
   logic [WIDTH-1:0] next_period;
   logic [WIDTH-1:0] next_offset;
   logic             next_dir;

   pwm_reload_unit #(
      .PEERS(PEERS)
   ) u_reload (
      .clock_in               (clock_in),
      .rst_b_in               (rst_b_in),
      .enable_in              (enable_in),
      .arm_set_in             (load_arm_set_in),
      .arm_clear_in           (load_arm_clear_in),
      .load_on_trigger_in     (load_on_trigger_in),
      .load_trigger_select_in (load_trigger_select_in),
      .peer_load_in           (peer_load_in),
      .period_event_in        (next_period_ev),
      .load_arm_out           (load_arm_out),
      .load_event_out         (reload_pulse)
   );

   always_comb begin
      load_now    = reload_pulse || !enable_in;
      next_phase  = phase_active_out;
      next_duty   = duty_active_out;
      next_period = period_active_out;
      next_offset = offset_active_out;
      next_dir    = offset_match_direction_out;
      if (load_now) begin
         next_phase  = phase_count_in;
         next_duty   = duty_count_in;
         next_period = period_count_in;
         next_offset = offset_count_in;
         next_dir    = offset_direction_shadow_in;
      end
   end

   always_ff @(posedge clock_in) begin
      if (!rst_b_in) begin
         phase_active_out           <= COUNT_RESET;
         duty_active_out            <= COUNT_RESET;
         period_active_out          <= COUNT_RESET;
         offset_active_out          <= COUNT_RESET;
         offset_match_direction_out <= 1'b0;
         load_event_out             <= 1'b0;
      end else begin
         phase_active_out           <= next_phase;
         duty_active_out            <= next_duty;
         period_active_out          <= next_period;
         offset_active_out          <= next_offset;
         offset_match_direction_out <= next_dir;
         load_event_out             <= reload_pulse;
      end
   end

   // ----------------------------------------------------------------
   // Match flags
   // ----------------------------------------------------------------
   logic [3:0] match_vec;

   always_comb begin
      match_vec = {offset_match_event_out,
                   modulator_timer_out == phase_active_out,
                   modulator_timer_out == duty_active_out,
                   period_event_out};
   end

   pwm_match_flags u_flags (
      .clock_in      (clock_in),
      .rst_b_in      (rst_b_in),
      .enable_in     (enable_in),
      .match_in      (match_vec),
      .flag_clear_in (flag_clear_in),
      .irq_enable_in (irq_enable_in),
      .flag_out      (irq_flag_out),
      .irq_out       (irq_out)
   );

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   sequence s_wait_then_hit;
      state == RUN_WAIT && run_ok && master_hit;
   endsequence
   property p_slave_start;
      @(posedge clock_in) disable iff (!rst_b_in)
      s_wait_then_hit ##0 (offset_mode_select_in != OFFSET_INDEPENDENT)
      |=> state == RUN_COUNT;
   endproperty
   a_slave_start: assert property (p_slave_start)
      else $error("slave did not start on master match");
   property p_inhibit;
      @(posedge clock_in) disable iff (!rst_b_in)
      state == RUN_WAIT && !master_hit && enable_in &&
      offset_mode_select_in != OFFSET_INDEPENDENT
      |=> $stable(modulator_timer_out);
   endproperty
   a_inhibit: assert property (p_inhibit)
      else $error("timer moved while waiting");
   property p_restart_one;
      @(posedge clock_in) disable iff (!rst_b_in)
      state == RUN_COUNT && run_ok && seen_master && master_hit &&
      offset_mode_select_in == OFFSET_CONTINUOUS
      |=> modulator_timer_out == TIMER_RESTART;
   endproperty
   a_restart_one: assert property (p_restart_one)
      else $error("continuous slave not reloaded to one");
   property p_one_shot_stop;
      @(posedge clock_in) disable iff (!rst_b_in)
      period_event_out && offset_mode_select_in == OFFSET_ONE_SHOT &&
      !center && $past(offset_mode_select_in) == OFFSET_ONE_SHOT
      |-> state == RUN_STOPPED && modulator_timer_out == TIMER_ZERO;
   endproperty
   a_one_shot_stop: assert property (p_one_shot_stop)
      else $error("one-shot did not stop at period");
   property p_disabled_zero;
      @(posedge clock_in) disable iff (!rst_b_in)
      !enable_in |=> modulator_timer_out == TIMER_ZERO && !period_event_out;
   endproperty
   a_disabled_zero: assert property (p_disabled_zero)
      else $error("timer not cleared while disabled");
   property p_load_together;
      @(posedge clock_in) disable iff (!rst_b_in)
      reload_pulse && enable_in |=> period_active_out == $past(period_count_in)
      && offset_match_direction_out == $past(offset_direction_shadow_in);
   endproperty
   a_load_together: assert property (p_load_together)
      else $error("active counts not loaded together");
endmodule

/* File: design/pwm_reload_unit.sv */
module pwm_reload_unit
   import pwm_sync_pkg::*;
#(
   parameter int PEERS = PEER_N
) (
   // Clock and reset.
   input  wire logic               clock_in,
   input  wire logic               rst_b_in,
   // Control.
   input  wire logic               enable_in,
   input  wire logic               arm_set_in,
   input  wire logic               arm_clear_in,
   input  wire logic               load_on_trigger_in,
   input  wire logic [1:0]         load_trigger_select_in,
   input  wire logic [PEERS-1:0]   peer_load_in,
   input  wire logic               period_event_in,
   // Status.
   output logic                    load_arm_out,
   output logic                    load_event_out
);
   // ----------------------------------------------------------------
   // Arming state
   // ----------------------------------------------------------------
   logic armed;
   logic triggered;
   logic next_armed;
   logic next_triggered;
   logic next_load;
   logic trig_hit;

   always_comb begin
      trig_hit = 1'b0;
      if (load_trigger_select_in < PEERS[1:0]) begin
         trig_hit = peer_load_in[load_trigger_select_in];
      end
      next_armed     = armed;
      next_triggered = triggered;
      next_load      = 1'b0;
      if (armed && period_event_in &&
          (!load_on_trigger_in || triggered)) begin
         next_load      = 1'b1;
         next_armed     = 1'b0;
         next_triggered = 1'b0;
      end else if (armed && load_on_trigger_in && trig_hit &&
                   !period_event_in) begin
         next_triggered = 1'b1;
      end
      if (arm_clear_in) begin
         next_armed     = 1'b0;
         next_triggered = 1'b0;
      end
      if (arm_set_in) begin
         next_armed = 1'b1;
      end
      if (!enable_in) begin
         next_triggered = 1'b0;
      end
   end

   always_ff @(posedge clock_in) begin
      if (!rst_b_in) begin
         armed          <= 1'b0;
         triggered      <= 1'b0;
         load_event_out <= 1'b0;
      end else begin
         armed          <= next_armed;
         triggered      <= next_triggered;
         load_event_out <= next_load;
      end
   end

   assign load_arm_out = armed;

   property p_load_clears_arm;
      @(posedge clock_in) disable iff (!rst_b_in)
      (load_event_out && !$past(arm_set_in)) |-> !armed;
   endproperty
   a_load_clears_arm: assert property (p_load_clears_arm)
      else $error("arm not cleared by load");
   property p_arm_late;
      @(posedge clock_in) disable iff (!rst_b_in)
      arm_set_in && !armed && period_event_in |=> !load_event_out;
   endproperty
   a_arm_late: assert property (p_arm_late)
      else $error("arm at period match loaded at once");
   property p_load_needs_arm;
      @(posedge clock_in) disable iff (!rst_b_in)
      load_event_out |-> $past(armed) && $past(period_event_in);
   endproperty
   a_load_needs_arm: assert property (p_load_needs_arm)
      else $error("load without arm and period");
endmodule

/* File: design/pwm_sync_pkg.sv */
package pwm_sync_pkg;
   // ----------------------------------------------------------------
   // Widths
   // ----------------------------------------------------------------
   localparam int COUNT_W = 16;
   localparam int PEER_N  = 3;

   // ----------------------------------------------------------------
   // Offset modes
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      OFFSET_INDEPENDENT = 2'b00,
      OFFSET_SLAVE_RUN   = 2'b01,
      OFFSET_ONE_SHOT    = 2'b10,
      OFFSET_CONTINUOUS  = 2'b11
   } offset_mode_t;

   // ----------------------------------------------------------------
   // Waveform modes
   // ----------------------------------------------------------------
   localparam logic [1:0] WAVE_CENTER = 2'b11;

   // ----------------------------------------------------------------
   // Clock source codes
   // ----------------------------------------------------------------
   localparam logic [1:0] CLK_SRC_FAST_OSC = 2'b01;
   localparam logic [1:0] CLK_SRC_SLOW_OSC = 2'b10;

   // ----------------------------------------------------------------
   // Reset and reload values
   // ----------------------------------------------------------------
   localparam logic [15:0] TIMER_ZERO      = 16'h0000;
   localparam logic [15:0] TIMER_RESTART   = 16'h0001;
   localparam logic [15:0] COUNT_RESET     = 16'h0000;

   // ----------------------------------------------------------------
   // Timer run states
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      RUN_IDLE    = 2'b00,
      RUN_WAIT    = 2'b01,
      RUN_COUNT   = 2'b10,
      RUN_STOPPED = 2'b11
   } run_state_t;
endpackage

/* File: dv/master_pwm_model.sv */
module master_pwm_model (
   // Clock.
   input  wire logic clock_in,
   // Events to the slave.
   output logic [2:0] offset_match_out,
   output logic [2:0] load_out
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      offset_match_out = 3'h0;
      load_out = 3'h0;
   end
   // Shares the slave clock, so it is never slower than the slave.
   // One-cycle offset-match or buffer-load pulse of peer idx.
   task automatic fire(input int idx, input logic is_load);
      if (is_load) begin
         load_out[idx] = 1'b1;
      end else begin
         offset_match_out[idx] = 1'b1;
      end
      @(posedge clock_in);
      #1;
      offset_match_out = 3'h0;
      load_out = 3'h0;
   endtask
endmodule

/* File: dv/pwm_offset_sync_reload_test.sv */
module pwm_offset_sync_reload_test import pwm_sync_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   logic clock_in, rst_b_in, enable, arm_set, trig, dir;
   logic [1:0] mode, lds, wave;
   logic [15:0] ph, dc, pr, of, tmr, ph_a, dc_a, pr_a, of_a;
   logic down, offset_mode_select, pev, lev, arm, dir_a;
   logic [3:0] irq_en, flags, irq;
   logic [2:0] peer_of, peer_ld;
   int n_mismatch, comparisons, cyc;
   master_pwm_model i_master_pwm_model (.clock_in(clock_in),
      .offset_match_out(peer_of), .load_out(peer_ld));
   pwm_offset_sync_reload i_pwm_offset_sync_reload (.clock_in(clock_in),
      .rst_b_in(rst_b_in), .enable_in(enable), .wave_mode_in(wave),
      .sleep_in(1'b0), .clock_source_in(2'b00),
      .offset_mode_select_in(mode), .offset_source_select_in(2'b00),
      .peer_offset_match_in(peer_of), .phase_count_in(ph),
      .duty_count_in(dc), .period_count_in(pr), .offset_count_in(of),
      .offset_direction_shadow_in(dir), .load_arm_set_in(arm_set),
      .load_arm_clear_in(1'b0), .load_on_trigger_in(trig),
      .load_trigger_select_in(lds), .peer_load_in(peer_ld),
      .irq_enable_in(irq_en), .flag_clear_in(4'h0),
      .modulator_timer_out(tmr), .counting_down_out(down),
      .offset_match_event_out(offset_mode_select), .period_event_out(pev),
      .load_event_out(lev), .load_arm_out(arm), .phase_active_out(ph_a),
      .duty_active_out(dc_a), .period_active_out(pr_a),
      .offset_active_out(of_a), .offset_match_direction_out(dir_a),
      .irq_flag_out(flags), .irq_out(irq));
   initial begin
      clock_in = 1'b0;
      forever #4 clock_in = ~clock_in;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge clock_in);
      #1;
   endtask
   task automatic check(input string what, input logic [15:0] e, g);
      comparisons++;
      if (g !== e) begin
         n_mismatch++;
         $display("CHECK FAILED %s expected %h seen %h", what, e, g);
      end
   endtask
   task automatic wait_tmr(input logic [15:0] v);
      for (int i = 0; i < 200 && tmr !== v; i++) tick(1);
      check("timer value", v, tmr);
   endtask
   task automatic wait_load();
      for (int i = 0; i < 200 && lev !== 1'b1; i++) tick(1);
      check("load event", 16'h0001, {15'h0, lev});
   endtask
   task automatic restart(input logic [1:0] m);
      rst_b_in = 1'b0;
      enable = 1'b0;
      mode = m;
      tick(8);
      rst_b_in = 1'b1;
      tick(1);
      enable = 1'b1;
      tick(1);
   endtask
   task automatic t_indep();
      restart(2'b00);
      wait_tmr(pr);
      tick(1);
      check("timer wrap", 16'h0000, tmr);
      check("period event", 16'h0001, {15'h0, pev});
      tick(2);
      check("flags", 16'h000f, {12'h0, flags});
      check("irq", 16'h0001, {12'h0, irq});
      enable = 1'b0;
      tick(2);
      check("flags off", 16'h0000, {12'h0, flags});
      $display("end of t_indep");
   endtask
   task automatic t_slaves();
      restart(2'b01);
      tick(6);
      check("slave hold", 16'h0000, tmr);
      i_master_pwm_model.fire(0, 1'b0);
      wait_tmr(pr);
      tick(2);
      check("slave run", 16'h0001, tmr);
      restart(2'b10);
      i_master_pwm_model.fire(0, 1'b0);
      wait_tmr(pr);
      tick(3);
      check("one shot stop", 16'h0000, tmr);
      i_master_pwm_model.fire(0, 1'b0);
      wait_tmr(pr);
      pr = 16'h0008;
      restart(2'b11);
      tick(6);
      check("inhibited", 16'h0000, tmr);
      i_master_pwm_model.fire(0, 1'b0);
      wait_tmr(16'h0005);
      i_master_pwm_model.fire(0, 1'b0);
      check("restart one", 16'h0001, tmr);
      wait_tmr(pr);
      tick(1);
      check("own period", 16'h0000, tmr);
      pr = 16'h0003;
      $display("end of t_slaves");
   endtask
   task automatic t_center();
      wave = 2'b11;
      for (int d = 0; d < 2; d++) begin
         dir = d[0];
         restart(2'b00);
         wait_tmr(16'h0001);
         tick(1);
         check("up match", {15'h0, ~dir}, {15'h0, offset_mode_select});
         tick(3);
         check("down", 16'h0001, {15'h0, down});
         tick(1);
         check("down match", {15'h0, dir}, {15'h0, offset_mode_select});
      end
      wave = 2'b00;
      restart(2'b00);
      wait_tmr(16'h0001);
      tick(1);
      check("no dir effect", 16'h0001, {15'h0, offset_mode_select});
      dir = 1'b0;
      $display("end of t_center");
   endtask
   task automatic t_reload();
      restart(2'b00);
      pr = 16'h0005;
      dc = 16'h0004;
      dir = 1'b1;
      {ph, of} = {16'h0002, 16'h0002};
      tick(10);
      check("no early load", 16'h0003, pr_a);
      arm_set = 1'b1;
      tick(1);
      arm_set = 1'b0;
      wait_load();
      check("period", 16'h0005, pr_a);
      check("duty", 16'h0004, dc_a);
      check("dir", 16'h0001, {15'h0, dir_a});
      check("arm clear", 16'h0000, {15'h0, arm});
      check("phase", 16'h0002, ph_a);
      check("offset", 16'h0002, of_a);
      trig = 1'b1;
      lds = 2'b01;
      pr = 16'h0004;
      arm_set = 1'b1;
      tick(1);
      arm_set = 1'b0;
      tick(20);
      check("wait trig", 16'h0005, pr_a);
      check("armed", 16'h0001, {15'h0, arm});
      i_master_pwm_model.fire(1, 1'b1);
      wait_load();
      check("trig load", 16'h0004, pr_a);
      check("trig arm clear", 16'h0000, {15'h0, arm});
      trig = 1'b0;
      pr = 16'h0006;
      wait_tmr(16'h0004);
      arm_set = 1'b1;
      tick(1);
      arm_set = 1'b0;
      tick(1);
      check("late arm no load", 16'h0000, {15'h0, lev});
      check("late arm period", 16'h0004, pr_a);
      wait_load();
      check("late arm load", 16'h0006, pr_a);
      $display("end of t_reload");
   endtask
   task automatic report_and_stop();
      $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   always @(posedge clock_in) begin
      cyc++;
      if (cyc == 5000) begin
         n_mismatch++;
         report_and_stop();
      end
   end
   initial begin
      {arm_set, trig, dir, lds, wave} = '0;
      {ph, dc, pr, of} = {16'h0001, 16'h0002, 16'h0003, 16'h0001};
      irq_en = 4'h1;
      t_indep();
      t_slaves();
      t_center();
      t_reload();
      report_and_stop();
   end
endmodule
